// >>> logic/spinv_pkg.sv
/*
 * Package of the SPI nonvolatile memory target: command codes, status
 * register field positions, reset values, guard regions and carrier types.
 * Assumes nothing of its surroundings; imported whole by the design.
 */
package spinv_pkg;

   // Array and write queue geometry
   localparam int SPINV_ADDR_W = 13;
   localparam int SPINV_DEPTH = 8192;
   localparam int SPINV_FIFO_DEPTH = 8;

   // Command codes, sent most significant bit first
   localparam logic [7:0] SPINV_OP_SET_LATCH = 8'h06;
   localparam logic [7:0] SPINV_OP_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] SPINV_OP_STATUS_READ = 8'h05;
   localparam logic [7:0] SPINV_OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] SPINV_OP_MEM_READ = 8'h03;
   localparam logic [7:0] SPINV_OP_MEM_WRITE = 8'h02;

   // Status register field positions
   localparam int SPINV_ST_GUARD_EN = 7;
   localparam int SPINV_ST_SPARE_HI = 6;
   localparam int SPINV_ST_SPARE_LO = 4;
   localparam int SPINV_ST_BLOCK_HI = 3;
   localparam int SPINV_ST_BLOCK_LO = 2;
   localparam int SPINV_ST_LATCH = 1;
   localparam int SPINV_ST_ZERO = 0;

   // Reset values: delivered contents of the stored bits, latch clear
   localparam logic [5:0] SPINV_NV_RESET = 6'h00;
   localparam logic SPINV_LATCH_RESET = 1'b0;

   // Lowest guarded address for block guard codes 01 and 10
   localparam logic [12:0] SPINV_GUARD_QUARTER = 13'h1800;
   localparam logic [12:0] SPINV_GUARD_HALF = 13'h1000;

   // Transfer phases, Gray coded along opcode, address, data
   typedef enum logic [2:0] {
      SPINV_ST_CMD = 3'b000,
      SPINV_ST_ADR_HI = 3'b001,
      SPINV_ST_ADR_LO = 3'b011,
      SPINV_ST_DATA = 3'b010,
      SPINV_ST_SKIP = 3'b110
   } spinv_phase_t;

   // One queued array write
   typedef struct packed {
      logic [12:0] addr;
      logic [7:0] data;
   } spinv_wr_t;

endpackage

// >>> logic/spinv_top.sv
/*
 * SPI nonvolatile memory target: pin synchronisers, command decoder,
 * status register, write queue and the 8,192 x 8 array.
 * Assumes the pins arrive asynchronously to i_clock, with SCK well below
 * a quarter of the i_clock rate; the SO pin is resolved by the bench.
 */
`timescale 1ns/100ps

module spinv_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 8
) (
   // Clock and control
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // Drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0] wr_q;
   logic [PW:0] rd_q;
   logic push;
   logic pop;

   // Full when pointers differ only in the wrap bit
   assign o_ready = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
   assign o_valid = (wr_q != rd_q);
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   assign o_data = mem_q[rd_q[PW-1:0]];

   // Storage, written only on an accepted push
   always_ff @(posedge i_clock) begin
      if (i_clk_en && push) begin
         mem_q[wr_q[PW-1:0]] <= i_data;
      end
   end

   // Pointers
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (i_clk_en) begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

module spinv_top
   import spinv_pkg::*;
#(
   parameter int ADDR_W = SPINV_ADDR_W,
   parameter int FIFO_DEPTH = SPINV_FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // SPI pins, all inputs; the serial clock is never driven here
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic i_wp_n,
   input wire logic i_hold_n,
   // Serial output with active-low enable
   output logic o_so,
   output logic o_so_oe_n,
   // Observation
   output logic [7:0] o_status,
   output logic o_standby,
   output logic o_queue_full
);
   // Pin synchronisers, two flops each
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic sck_prev_q;
   logic cs_n_s;
   logic sck_s;
   logic si_s;
   logic wp_n_s;
   logic hold_n_s;
   logic active;
   logic sck_rise;
   logic sck_fall;

   // Transfer state
   spinv_phase_t phase_q;
   logic [7:0] op_q;
   logic [2:0] bit_q;
   logic [6:0] shift_q;
   logic [15:0] adr_q;
   logic [7:0] tx_q;
   logic so_q;
   logic so_oe_n_q;
   logic reading_q;
   logic cs_prev_n_q;
   logic [7:0] rx_byte;
   logic byte_done;
   logic [ADDR_W-1:0] cur_addr;

   // Status register storage
   logic [5:0] nv_q;
   logic latch_q;
   logic [7:0] status;
   logic status_locked;

   // Array and write queue
   logic [7:0] array_q [2**ADDR_W];
   spinv_wr_t wr_in;
   spinv_wr_t wr_out;
   logic wr_push;
   logic q_ready;
   logic q_valid;
   logic q_take;

   // Guarded-block test against the block guard code
   function automatic logic guarded(input logic [1:0] bp, input logic [12:0] a);
      case (bp)
         2'b00: guarded = 1'b0;
         2'b01: guarded = (a >= SPINV_GUARD_QUARTER);
         2'b10: guarded = (a >= SPINV_GUARD_HALF);
         default: guarded = 1'b1;
      endcase
   endfunction

   // Pins cross into the i_clock domain; only stage two is read
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sync1_q <= 5'h1F;
         sync2_q <= 5'h1F;
         sck_prev_q <= 1'b0;
         cs_prev_n_q <= 1'b1;
      end else if (i_clk_en) begin
         sync1_q <= {i_cs_n, i_sck, i_si, i_wp_n, i_hold_n};
         sync2_q <= sync1_q;
         sck_prev_q <= sync2_q[3];
         cs_prev_n_q <= sync2_q[4];
      end
   end

   assign cs_n_s = sync2_q[4];
   assign sck_s = sync2_q[3];
   assign si_s = sync2_q[2];
   assign wp_n_s = sync2_q[1];
   assign hold_n_s = sync2_q[0];
   // Selected and not held: only then do clock edges count
   assign active = !cs_n_s && hold_n_s;
   // Same edges in mode 0 and mode 3; idle level never matters
   assign sck_rise = active && sck_s && !sck_prev_q;
   assign sck_fall = active && !sck_s && sck_prev_q;

   // Byte assembly, first bit is the most significant
   assign rx_byte = {shift_q, si_s};
   assign byte_done = sck_rise && (bit_q == 3'h7);
   assign cur_addr = adr_q[ADDR_W-1:0];

   // Bit 0 fixed zero, latch shown at bit 1
   assign status = {nv_q, latch_q, 1'b0};
   // Status locked by guard enable with a low protect pin
   assign status_locked = nv_q[SPINV_ST_GUARD_EN-2] && !wp_n_s;

   // Bit counter and input shifter, sampled on rising edges
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         bit_q <= 3'h0;
         shift_q <= 7'h00;
      end else if (i_clk_en) begin
         if (cs_n_s) begin
            bit_q <= 3'h0; // Partial opcode is dropped
         end else if (sck_rise) begin
            bit_q <= bit_q + 3'h1;
            shift_q <= rx_byte[6:0];
         end
      end
   end

   // Phase machine: opcode, address, data; deselect restarts it
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         phase_q <= SPINV_ST_CMD;
         op_q <= 8'h00;
         adr_q <= 16'h0000;
      end else if (i_clk_en) begin
         if (cs_n_s) begin
            phase_q <= SPINV_ST_CMD;
         end else if (byte_done) begin
            case (phase_q)
               SPINV_ST_CMD: begin
                  op_q <= rx_byte;
                  if (rx_byte == SPINV_OP_STATUS_READ ||
                      rx_byte == SPINV_OP_STATUS_WRITE) begin
                     phase_q <= SPINV_ST_DATA;
                  end else if (rx_byte == SPINV_OP_MEM_READ ||
                               rx_byte == SPINV_OP_MEM_WRITE) begin
                     phase_q <= SPINV_ST_ADR_HI;
                  end else begin
                     phase_q <= SPINV_ST_SKIP;
                  end
               end
               SPINV_ST_ADR_HI: begin
                  adr_q[15:8] <= rx_byte;
                  phase_q <= SPINV_ST_ADR_LO;
               end
               SPINV_ST_ADR_LO: begin
                  // Read fetches the first byte now, so step past it
                  if (op_q == SPINV_OP_MEM_READ) begin
                     adr_q <= {adr_q[15:8], rx_byte} + 16'h0001;
                  end else begin
                     adr_q <= {adr_q[15:8], rx_byte};
                  end
                  phase_q <= SPINV_ST_DATA;
               end
               SPINV_ST_DATA: begin
                  // Upper bits ignored, so the count wraps at the top
                  if (op_q == SPINV_OP_MEM_READ || op_q == SPINV_OP_MEM_WRITE) begin
                     adr_q <= {3'h0, cur_addr + 13'h0001};
                  end
               end
               SPINV_ST_SKIP: phase_q <= SPINV_ST_SKIP;
               default: phase_q <= SPINV_ST_CMD;
            endcase
         end
      end
   end

   // Output loader and shifter; new bit on each falling edge
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tx_q <= 8'h00;
         so_q <= 1'b0;
         reading_q <= 1'b0;
      end else if (i_clk_en) begin
         if (cs_n_s) begin
            reading_q <= 1'b0;
         end else if (byte_done) begin
            if (phase_q == SPINV_ST_CMD && rx_byte == SPINV_OP_STATUS_READ) begin
               tx_q <= status;
               reading_q <= 1'b1;
            end else if (phase_q == SPINV_ST_DATA && op_q == SPINV_OP_STATUS_READ) begin
               tx_q <= status; // Repeated status while clocks continue
            end else if ((phase_q == SPINV_ST_ADR_LO || phase_q == SPINV_ST_DATA) &&
                         op_q == SPINV_OP_MEM_READ) begin
               // Fresh address in the low-address phase, running one after
               tx_q <= (phase_q == SPINV_ST_ADR_LO) ?
                       array_q[{adr_q[ADDR_W-1:8], rx_byte}] : array_q[cur_addr];
               reading_q <= 1'b1;
            end
         end else if (sck_fall) begin
            so_q <= tx_q[7]; // Most significant first
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // Output enable low only while selected, not held and reading
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         so_oe_n_q <= 1'b1;
      end else if (i_clk_en) begin
         so_oe_n_q <= !(active && reading_q);
      end
   end

   // Stored status bits; the latch position of the data is dropped
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         nv_q <= SPINV_NV_RESET; // Delivered zeros in spare bits
      end else if (i_clk_en) begin
         if (byte_done && phase_q == SPINV_ST_DATA && op_q == SPINV_OP_STATUS_WRITE &&
             latch_q && !status_locked) begin
            nv_q <= rx_byte[7:2]; // Guard enable, spares, block guard
         end
      end
   end

   // Write-enable latch
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         latch_q <= SPINV_LATCH_RESET; // Cleared at power-up
      end else if (i_clk_en) begin
         if (byte_done && phase_q == SPINV_ST_CMD && rx_byte == SPINV_OP_SET_LATCH) begin
            latch_q <= 1'b1;
         end else if (byte_done && phase_q == SPINV_ST_CMD &&
                      rx_byte == SPINV_OP_CLEAR_LATCH) begin
            latch_q <= 1'b0;
         end else if (cs_n_s && !cs_prev_n_q && phase_q != SPINV_ST_CMD &&
                      (op_q == SPINV_OP_STATUS_WRITE || op_q == SPINV_OP_MEM_WRITE)) begin
            // Cleared when the write command ends, so streams keep going
            latch_q <= 1'b0;
         end
      end
   end

   // Each received write byte is queued if latch set and block not guarded
   assign wr_in.addr = cur_addr;
   assign wr_in.data = rx_byte;
   assign wr_push = byte_done && phase_q == SPINV_ST_DATA && op_q == SPINV_OP_MEM_WRITE &&
                    latch_q && !guarded(nv_q[SPINV_ST_BLOCK_HI-2:SPINV_ST_BLOCK_LO-2],
                                        cur_addr);

   spinv_fifo #(
      .WIDTH($bits(spinv_wr_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_queue (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_valid(wr_push),
      .o_ready(q_ready),
      .i_data(wr_in),
      .o_valid(q_valid),
      .i_ready(q_take),
      .o_data(wr_out)
   );

   // Queue drains stall on byte ends, the cycle the array is read
   assign q_take = !byte_done;

   // Array update; drains in one cycle per byte, far faster than SCK
   always_ff @(posedge i_clock) begin
      if (i_clk_en && q_valid && q_take) begin
         array_q[wr_out.addr] <= wr_out.data;
      end
   end

   // Standby only after the queue has emptied
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_standby <= 1'b1;
         o_status <= 8'h00;
         o_queue_full <= 1'b0;
      end else if (i_clk_en) begin
         o_standby <= cs_n_s && !q_valid;
         o_status <= status;
         o_queue_full <= !q_ready;
      end
   end

   assign o_so = so_q;
   assign o_so_oe_n = so_oe_n_q;
endmodule

// >>> sim/spinv_top_monitor.sv
/* Port checker for spinv_top.
   Assumes SCK half periods of at least 4 clocks. */
`timescale 1ns/100ps
module spinv_top_monitor
   import spinv_pkg::*;
#(
   parameter int ADDR_W = SPINV_ADDR_W,
   parameter int FIFO_DEPTH = SPINV_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Pins
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic i_wp_n,
   input wire logic i_hold_n,
   input wire logic o_so,
   input wire logic o_so_oe_n,
   // Observation
   input wire logic [7:0] o_status,
   input wire logic o_standby,
   input wire logic o_queue_full
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // Margins cover the two-flop synchroniser plus output register
   a_zero_bit: assert property (o_status[0] == 1'b0)
      else $error("status bit 0 not zero");
   a_float_idle: assert property (i_cs_n [*6] |-> o_so_oe_n)
      else $error("output driven while deselected");
   a_hold_float: assert property (!i_hold_n [*6] |-> o_so_oe_n)
      else $error("output driven during hold");
   a_busy_sel: assert property (!i_cs_n [*6] |-> !o_standby)
      else $error("standby while selected");
   a_idle_stby: assert property (i_cs_n [*8] |-> o_standby)
      else $error("no standby after deselect");
   a_idle_quiet: assert property (i_cs_n [*8] |-> $stable(o_status))
      else $error("status moved while deselected");
   a_so_fall: assert property ($changed(o_so) && !o_so_oe_n && !$past(o_so_oe_n) |-> !$past(i_sck, 2))
      else $error("output changed away from falling clock");
   a_no_stall: assert property (!o_queue_full)
      else $error("write queue filled");
endmodule
bind spinv_top spinv_top_monitor #(.ADDR_W(ADDR_W), .FIFO_DEPTH(FIFO_DEPTH)) u_mon (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_cs_n(i_cs_n),
   .i_sck(i_sck), .i_si(i_si), .i_wp_n(i_wp_n), .i_hold_n(i_hold_n), .o_so(o_so),
   .o_so_oe_n(o_so_oe_n), .o_status(o_status), .o_standby(o_standby),
   .o_queue_full(o_queue_full));

// >>> sim/spinv_master.sv
/* SPI master model, the target's far side.
   Assumes an 80 ns serial clock; timing is free of the system clock. */
`timescale 1ns/100ps
module spinv_master (
   // Target output
   input wire logic i_so,
   input wire logic i_so_oe_n,
   // Master pins
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si,
   output logic o_wp_n,
   output logic o_hold_n
);
   logic cpol = 1'b0;
   int hold_at = -1;
   logic last_so = 1'b0;
   // Floating line shows the inverse, never a stale value
   wire so_seen = i_so_oe_n ? ~last_so : i_so;
   always @(i_so or i_so_oe_n) if (!i_so_oe_n) last_so = i_so;
   // Idle pins
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
      o_wp_n = 1'b1;
      o_hold_n = 1'b1;
   end
   // Clock idles at cpol; select before any bit
   task open;
      o_sck = cpol;
      #40 o_cs_n = 1'b0;
      #40;
   endtask
   task close;
      o_sck = cpol;
      #40 o_cs_n = 1'b1;
      o_si = ~o_si;
      #160;
   endtask
   // Bits leave MSB first, changed with clock low
   task bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         o_sck = 1'b0;
         o_si = tx[7-i];
         if (i == hold_at) begin
            #40 o_hold_n = 1'b0;
            // Clock and data wiggle while paused
            repeat (2) begin
               #40 o_sck = 1'b1;
               o_si = ~o_si;
               #40 o_sck = 1'b0;
            end
            o_si = tx[7-i];
            #40 o_hold_n = 1'b1;
         end
         #40 o_sck = 1'b1;
         #39 rx = {rx[6:0], so_seen};
         #1;
      end
   endtask
endmodule

// >>> sim/test_spinv_top.sv
/* Self-checking bench for spinv_top.
   Assumes spinv_master drives every pin and the checker is bound. */
`timescale 1ns/100ps
module test_spinv_top;
   import spinv_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic so, so_oe_n, cs_n, sck, si, wp_n, hold_n, standby, qfull;
   logic [7:0] status, r0, r1;
   logic [12:0] bound [1:3];
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   always #5 i_clock = ~i_clock;
   spinv_top u_spinv_top (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
      .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(wp_n), .i_hold_n(hold_n),
      .o_so(so), .o_so_oe_n(so_oe_n), .o_status(status), .o_standby(standby),
      .o_queue_full(qfull));
   spinv_master u_spinv_master (.i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n),
      .o_sck(sck), .o_si(si), .o_wp_n(wp_n), .o_hold_n(hold_n));
   task complete_run;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One whole frame: opcode, address for array commands, data
   task frame(input logic [7:0] op, input logic [15:0] adr, input int n,
              input logic [7:0] d0, input logic [7:0] d1);
      u_spinv_master.open();
      u_spinv_master.bits(op, 8, r0);
      if (op == SPINV_OP_MEM_READ || op == SPINV_OP_MEM_WRITE) begin
         u_spinv_master.bits(adr[15:8], 8, r0);
         u_spinv_master.bits(adr[7:0], 8, r0);
      end
      if (n > 0) u_spinv_master.bits(d0, 8, r0);
      if (n > 1) u_spinv_master.bits(d1, 8, r1);
      u_spinv_master.close();
   endtask
   task st_wr(input logic [7:0] v);
      frame(SPINV_OP_SET_LATCH, 16'h0000, 0, 8'h00, 8'h00);
      frame(SPINV_OP_STATUS_WRITE, 16'h0000, 1, v, 8'h00);
   endtask
   // Two bytes in one frame: status repeats
   task st_rd(input logic [7:0] e);
      frame(SPINV_OP_STATUS_READ, 16'h0000, 2, 8'h00, 8'h00);
      chk(r0, e);
      chk(r1, e);
   endtask
   task mw(input logic [15:0] adr, input logic [7:0] a, input logic [7:0] b);
      frame(SPINV_OP_SET_LATCH, 16'h0000, 0, 8'h00, 8'h00);
      frame(SPINV_OP_MEM_WRITE, adr, 2, a, b);
   endtask
   task mr(input logic [15:0] adr, input logic [7:0] a, input logic [7:0] b);
      frame(SPINV_OP_MEM_READ, adr, 2, 8'h00, 8'h00);
      chk(r0, a);
      chk(r1, b);
   endtask
   // Hang guard, about three times the expected run
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         complete_run;
      end
   end
   initial begin
      bound[1] = SPINV_GUARD_QUARTER;
      bound[2] = SPINV_GUARD_HALF;
      bound[3] = 13'h0000;
      repeat (4) @(posedge i_clock);
      #1 i_rst_n = 1'b1;
      repeat (4) @(posedge i_clock);
      st_rd(8'h00);
      chk(status, 8'h00);
      frame(SPINV_OP_SET_LATCH, 16'h0000, 0, 8'h00, 8'h00);
      st_rd(8'h02);
      frame(SPINV_OP_CLEAR_LATCH, 16'h0000, 0, 8'h00, 8'h00);
      st_rd(8'h00);
      // Opcode cut after four bits does nothing
      u_spinv_master.open();
      u_spinv_master.bits(SPINV_OP_SET_LATCH, 4, r0);
      u_spinv_master.close();
      st_rd(8'h00);
      $display("test latch done");
      st_wr(8'hFF);
      st_rd(8'hFC);
      chk(status, 8'hFC);
      u_spinv_master.o_wp_n = 1'b0;
      st_wr(8'h00);
      st_rd(8'hFC);
      u_spinv_master.o_wp_n = 1'b1;
      st_wr(8'h00);
      st_rd(8'h00);
      $display("test status done");
      mw(16'h0010, 8'h5A, 8'h5B);
      st_rd(8'h00);
      frame(SPINV_OP_MEM_WRITE, 16'h0010, 2, 8'hA5, 8'hA6);
      mr(16'h0010, 8'h5A, 8'h5B);
      mw(16'hFFFF, 8'h11, 8'h22);
      mr(16'h1FFF, 8'h11, 8'h22);
      $display("test array done");
      // Each guard code against its lowest guarded address
      for (int c = 1; c < 4; c++) begin
         st_wr(8'h00);
         mw({3'b000, bound[c] - 13'h0001}, 8'(c), 8'(c + 16));
         st_wr(8'(c << 2));
         mw({3'b000, bound[c] - 13'h0001}, 8'hAA, 8'hBB);
         mr({3'b000, bound[c] - 13'h0001}, (c == 3) ? 8'(c) : 8'hAA, 8'(c + 16));
      end
      $display("test guard done");
      u_spinv_master.cpol = 1'b1;
      u_spinv_master.hold_at = 3;
      st_rd(8'h0C);
      u_spinv_master.hold_at = -1;
      st_rd(8'h0C);
      chk({7'h00, so_oe_n}, 8'h01);
      chk({7'h00, standby}, 8'h01);
      $display("test mode and hold done");
      complete_run;
   end
endmodule
